// ==== pkg/dspmaf_map.svh ====
`ifndef DSPMAF_MAP_SVH
`define DSPMAF_MAP_SVH
`define DSPMAF_CTRL 8'h00
`define DSPMAF_ROUTE 8'h04
`define DSPMAF_PAT 8'h08
`define DSPMAF_MSK 8'h0c
`define DSPMAF_STS 8'h10
`define DSPMAF_IEN 8'h14
`define DSPMAF_RES 8'h18
`define DSPMAF_FLG 8'h1c
`define DSPMAF_B_DUAL 0
`define DSPMAF_B_SUB0 1
`define DSPMAF_B_SUB1 2
`define DSPMAF_B_ACC 3
`define DSPMAF_B_UIN 4
`define DSPMAF_B_UPIPE 5
`define DSPMAF_B_UOUT 6
`define DSPMAF_ROUTE_W 8
`define DSPMAF_CSEL 0
`define DSPMAF_ESEL 2
`define DSPMAF_RSEL 4
`define DSPMAF_CTRL_RST 32'h0000_0000
`define DSPMAF_ROUTE_RST 32'h0000_0000
`define DSPMAF_RESP_OK 2'h0
`define DSPMAF_RESP_ERR 2'h2
`endif

// ==== pkg/dspmaf_pkg.sv ====
package dspmaf_pkg;
   typedef enum logic [2:0] {
      F_ZERO = 3'h0,
      F_ZMSK = 3'h1,
      F_OMSK = 3'h2,
      F_PAT = 3'h3,
      F_PATB = 3'h4,
      F_OVER = 3'h5,
      F_UNDER = 3'h6,
      F_WRAP = 3'h7
   } dspmaf_flag_t;
   typedef enum logic [1:0] {
      G_IN = 2'h0,
      G_PIPE = 2'h1,
      G_OUT = 2'h2
   } dspmaf_grp_t;
   typedef logic [7:0] dspmaf_flags_t;
endpackage : dspmaf_pkg

// ==== pkg/dspmaf_slice_if.sv ====
`timescale 1ns/1ps
interface dspmaf_slice_if #(parameter int OPW = 12, parameter int AW = 32);
   logic signed [OPW-1:0] ax, ay, bx, by;
   logic sub, use_in, use_pipe, tick_in, tick_pipe, clr_in, clr_pipe;
   logic signed [AW-1:0] prod, part;
   modport ctl (output ax, ay, bx, by, sub, use_in, use_pipe, tick_in,
      tick_pipe, clr_in, clr_pipe, input prod, part);
   modport slc (input ax, ay, bx, by, sub, use_in, use_pipe, tick_in,
      tick_pipe, clr_in, clr_pipe, output prod, part);
endinterface : dspmaf_slice_if

// ==== rtl/dspmaf_slice.sv ====
`timescale 1ns/1ps
module dspmaf_slice import dspmaf_pkg::*; #(
   parameter int OPW = 12,
   parameter int AW = 32
) (
   input wire logic aclk, // fabric clock
   input wire logic aresetn, // sync reset, low
   dspmaf_slice_if.slc s // operands in, products out
);
   logic signed [OPW-1:0] ax_reg, ay_reg, bx_reg, by_reg;
   logic signed [OPW-1:0] ax_d, ay_d, bx_d, by_d;
   logic signed [2*OPW-1:0] pa, pb, pa_reg, pb_reg, pa_d, pb_d;

   always_ff @(posedge aclk) begin
      if (!aresetn || s.clr_in) begin
         ax_reg <= '0;
         ay_reg <= '0;
         bx_reg <= '0;
         by_reg <= '0;
      end else if (s.tick_in) begin
         ax_reg <= s.ax;
         ay_reg <= s.ay;
         bx_reg <= s.bx;
         by_reg <= s.by;
      end
   end

   assign ax_d = s.use_in ? ax_reg : s.ax;
   assign ay_d = s.use_in ? ay_reg : s.ay;
   assign bx_d = s.use_in ? bx_reg : s.bx;
   assign by_d = s.use_in ? by_reg : s.by;
   assign pa = ax_d * ay_d;
   assign pb = bx_d * by_d;

   always_ff @(posedge aclk) begin
      if (!aresetn || s.clr_pipe) begin
         pa_reg <= '0;
         pb_reg <= '0;
      end else if (s.tick_pipe) begin
         pa_reg <= pa;
         pb_reg <= pb;
      end
   end

   assign pa_d = s.use_pipe ? pa_reg : pa;
   assign pb_d = s.use_pipe ? pb_reg : pb;
   assign s.prod = AW'(pa_d);
   // second product plus or minus the first
   assign s.part = s.sub ? AW'(pb_d) - AW'(pa_d)
                         : AW'(pb_d) + AW'(pa_d);
endmodule : dspmaf_slice

// ==== rtl/dspmaf_top.sv ====
`timescale 1ns/1ps
`include "dspmaf_map.svh"
module dspmaf_top import dspmaf_pkg::*; #(
   parameter int OPW = 12,
   parameter int AW = 32
) (
   input wire logic aclk, // 200 MHz clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic routed_clock_a, // routed clock pin 0
   input wire logic routed_clock_b, // routed clock pin 1
   input wire logic routed_clock_c, // routed clock pin 2
   input wire logic routed_clock_d, // routed clock pin 3
   input wire logic [3:0] fab_ce, // routed clock enables
   input wire logic [3:0] fab_rst, // routed resets
   input wire logic [2*OPW-1:0] first_pair_x, // per slice
   input wire logic [2*OPW-1:0] first_pair_y, // per slice
   input wire logic [2*OPW-1:0] second_pair_x, // per slice
   input wire logic [2*OPW-1:0] second_pair_y, // per slice
   output logic [AW-1:0] result_q, // element output
   output logic flag_all_zero, // result zero
   output logic flag_zero_masked, // unmasked bits zero
   output logic flag_ones_masked, // unmasked bits one
   output logic flag_pattern_match, // equals pattern
   output logic flag_inverse_pattern_match, // equals ~pattern
   output logic flag_acc_over, // accumulator overflow
   output logic flag_acc_under, // accumulator underflow
   output logic flag_acc_any_wrap, // either of the two
   output logic irq // level interrupt
);
   localparam logic signed [AW+1:0] ACC_MAX = {3'b000, {(AW-1){1'b1}}};
   localparam logic signed [AW+1:0] ACC_MIN = {3'b111, {(AW-1){1'b0}}};

   logic [31:0] ctrl_reg, route_reg;
   logic [AW-1:0] pat_reg, msk_reg, result_reg;
   dspmaf_flags_t flg_reg, sts_reg, ien_reg, flg_next, w1c;
   logic irq_reg;

   // pin synchronisers
   logic [11:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f;
   logic [3:0] ck_prev_reg, ck_tick;
   logic [2:0] grp_tick, grp_clr;
   assign pin_raw = {fab_rst, fab_ce, routed_clock_d, routed_clock_c,
                     routed_clock_b, routed_clock_a};
   for (genvar i = 0; i < 12; i++) begin : g_pin
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pin_s1[i] <= 1'b0;
            pin_s2[i] <= 1'b0;
            pin_s3[i] <= 1'b0;
            pin_f[i] <= 1'b0;
         end else begin
            pin_s1[i] <= pin_raw[i];
            pin_s2[i] <= pin_s1[i];
            pin_s3[i] <= pin_s2[i];
            if (pin_s2[i] == pin_s3[i]) begin
               pin_f[i] <= pin_s3[i];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ck_prev_reg <= 4'h0;
      end else begin
         ck_prev_reg <= pin_f[3:0];
      end
   end
   assign ck_tick = pin_f[3:0] & ~ck_prev_reg;

   // per group clock, enable and reset routing
   for (genvar g = 0; g < 3; g++) begin : g_grp
      logic [7:0] rt;
      assign rt = route_reg[g*`DSPMAF_ROUTE_W +: `DSPMAF_ROUTE_W];
      assign grp_tick[g] = ck_tick[rt[`DSPMAF_CSEL +: 2]]
                         & pin_f[4 + rt[`DSPMAF_ESEL +: 2]];
      assign grp_clr[g] = pin_f[8 + rt[`DSPMAF_RSEL +: 2]];
   end

   // two parallel slices, their outputs combined in the second ALU
   dspmaf_slice_if #(.OPW(OPW), .AW(AW)) sif[2] ();
   for (genvar i = 0; i < 2; i++) begin : g_slc
      assign sif[i].ax = first_pair_x[i*OPW +: OPW];
      assign sif[i].ay = first_pair_y[i*OPW +: OPW];
      assign sif[i].bx = second_pair_x[i*OPW +: OPW];
      assign sif[i].by = second_pair_y[i*OPW +: OPW];
      assign sif[i].sub = ctrl_reg[`DSPMAF_B_SUB0 + i];
      assign sif[i].use_in = ctrl_reg[`DSPMAF_B_UIN];
      assign sif[i].use_pipe = ctrl_reg[`DSPMAF_B_UPIPE];
      assign sif[i].tick_in = grp_tick[G_IN];
      assign sif[i].tick_pipe = grp_tick[G_PIPE];
      assign sif[i].clr_in = grp_clr[G_IN];
      assign sif[i].clr_pipe = grp_clr[G_PIPE];
      dspmaf_slice #(.OPW(OPW), .AW(AW)) u_slc (
         .aclk(aclk),
         .aresetn(aresetn),
         .s(sif[i])
      );
   end

   // second ALU, accumulator and flags
   logic dual, acc_on, use_out, res_upd, clr_out;
   logic signed [AW-1:0] alu_res, acc_base;
   logic signed [AW+1:0] acc_sum;
   logic [AW-1:0] res_next;
   assign dual = ctrl_reg[`DSPMAF_B_DUAL];
   assign acc_on = ctrl_reg[`DSPMAF_B_ACC];
   assign use_out = ctrl_reg[`DSPMAF_B_UOUT];
   assign alu_res = dual ? sif[0].part + sif[1].part
                         : sif[0].prod;
   assign acc_base = acc_on ? result_reg : '0;
   assign acc_sum = (AW+2)'(acc_base) + (AW+2)'(alu_res);
   assign res_next = acc_sum[AW-1:0];
   // bypassed output stage still lands in a flop, loaded every cycle
   assign res_upd = use_out ? grp_tick[G_OUT] : 1'b1;
   assign clr_out = use_out & grp_clr[G_OUT];

   always_comb begin
      flg_next[F_ZERO] = res_next == '0;
      flg_next[F_ZMSK] = (res_next & ~msk_reg) == '0;
      flg_next[F_OMSK] = (~res_next & ~msk_reg) == '0;
      flg_next[F_PAT] = ((res_next ^ pat_reg) & ~msk_reg) == '0;
      flg_next[F_PATB] = ((res_next ^ ~pat_reg) & ~msk_reg) == '0;
      flg_next[F_OVER] = acc_sum > ACC_MAX;
      flg_next[F_UNDER] = acc_sum < ACC_MIN;
      flg_next[F_WRAP] = flg_next[F_OVER] | flg_next[F_UNDER];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clr_out) begin
         result_reg <= '0;
         flg_reg <= '0;
      end else if (res_upd) begin
         result_reg <= res_next;
         flg_reg <= flg_next;
      end
   end

   // register bus, write side
   logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg;
   logic bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [7:0] awaddr_reg, wa, ra;
   logic [31:0] wdata_reg, rdata_reg, rd_data;
   logic [3:0] wstrb_reg;
   logic aw_hold_next, w_hold_next, bvalid_next, rvalid_next;
   logic do_wr, wr_ok, rd_ok;

   function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   assign wa = {awaddr_reg[7:2], 2'b00};
   assign do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;

   always_comb begin
      aw_hold_next = aw_hold_reg | (awvalid & awready_reg);
      w_hold_next = w_hold_reg | (wvalid & wready_reg);
      bvalid_next = bvalid_reg & ~bready;
      if (do_wr) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
      end
      case (wa)
         `DSPMAF_CTRL, `DSPMAF_ROUTE, `DSPMAF_PAT, `DSPMAF_MSK,
         `DSPMAF_STS, `DSPMAF_IEN, `DSPMAF_RES, `DSPMAF_FLG: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `DSPMAF_RESP_OK;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awready_reg <= ~aw_hold_next & ~bvalid_next;
         wready_reg <= ~w_hold_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (awvalid && awready_reg) begin
            awaddr_reg <= awaddr;
         end
         if (wvalid && wready_reg) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (do_wr) begin
            bresp_reg <= wr_ok ? `DSPMAF_RESP_OK : `DSPMAF_RESP_ERR;
         end
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `DSPMAF_CTRL_RST;
         route_reg <= `DSPMAF_ROUTE_RST;
         pat_reg <= '0;
         msk_reg <= '0;
         ien_reg <= '0;
      end else if (do_wr) begin
         case (wa)
            `DSPMAF_CTRL: ctrl_reg <= wmerge(ctrl_reg, wdata_reg, wstrb_reg);
            `DSPMAF_ROUTE: begin
               route_reg <= wmerge(route_reg, wdata_reg, wstrb_reg);
            end
            `DSPMAF_PAT: begin
               pat_reg <= AW'(wmerge(32'(pat_reg), wdata_reg, wstrb_reg));
            end
            `DSPMAF_MSK: begin
               msk_reg <= AW'(wmerge(32'(msk_reg), wdata_reg, wstrb_reg));
            end
            `DSPMAF_IEN: begin
               ien_reg <= 8'(wmerge(32'(ien_reg), wdata_reg, wstrb_reg));
            end
            default: ;
         endcase
      end
   end

   // sticky status, set wins over write-one-to-clear
   assign w1c = (do_wr && wa == `DSPMAF_STS)
              ? 8'(wmerge(32'h0, wdata_reg, wstrb_reg)) : 8'h00;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sts_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         sts_reg <= (sts_reg & ~w1c)
                  | ((res_upd && !clr_out) ? flg_next : 8'h00);
         irq_reg <= |(sts_reg & ien_reg);
      end
   end

   // register bus, read side
   assign ra = {araddr[7:2], 2'b00};
   always_comb begin
      rd_ok = 1'b1;
      case (ra)
         `DSPMAF_CTRL: rd_data = ctrl_reg;
         `DSPMAF_ROUTE: rd_data = route_reg;
         `DSPMAF_PAT: rd_data = 32'(pat_reg);
         `DSPMAF_MSK: rd_data = 32'(msk_reg);
         `DSPMAF_STS: rd_data = 32'(sts_reg);
         `DSPMAF_IEN: rd_data = 32'(ien_reg);
         `DSPMAF_RES: rd_data = 32'(result_reg);
         `DSPMAF_FLG: rd_data = 32'(flg_reg);
         default: begin
            rd_data = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
      rvalid_next = (rvalid_reg & ~rready) | (arvalid & arready_reg);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `DSPMAF_RESP_OK;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (arvalid && arready_reg) begin
            rdata_reg <= rd_data;
            rresp_reg <= rd_ok ? `DSPMAF_RESP_OK : `DSPMAF_RESP_ERR;
         end
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign result_q = result_reg;
   assign flag_all_zero = flg_reg[F_ZERO];
   assign flag_zero_masked = flg_reg[F_ZMSK];
   assign flag_ones_masked = flg_reg[F_OMSK];
   assign flag_pattern_match = flg_reg[F_PAT];
   assign flag_inverse_pattern_match = flg_reg[F_PATB];
   assign flag_acc_over = flg_reg[F_OVER];
   assign flag_acc_under = flg_reg[F_UNDER];
   assign flag_acc_any_wrap = flg_reg[F_WRAP];
   assign irq = irq_reg;

   // checks
   logic signed [AW-1:0] ref_p0, ref_d;
   logic all_byp;
   assign all_byp = ~|ctrl_reg[`DSPMAF_B_UOUT:`DSPMAF_B_ACC];
   assign ref_p0 = AW'($signed(first_pair_x[OPW-1:0]))
                 * AW'($signed(first_pair_y[OPW-1:0]));
   assign ref_d = sif[0].part + sif[1].part;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_out_step;
      res_upd && !clr_out;
   endsequence
   sequence s_b_wait;
      bvalid_reg && !bready;
   endsequence

   a_plain_plain_multiply_element: assert property (all_byp && !dual |=>
      result_reg == $past(ref_p0)) else $error("plain product wrong");
   a_out_hold: assert property (use_out && !grp_tick[G_OUT]
      && !clr_out |=> $stable(result_reg)) else $error("output moved");
   a_dual_sum: assert property (all_byp && dual |=>
      result_reg == $past(ref_d)) else $error("dual sum wrong");
   a_zero_flags: assert property (s_out_step |=>
      flg_reg[F_ZERO] == (result_reg == '0)
      && flg_reg[F_ZMSK] == ((result_reg & ~$past(msk_reg)) == '0))
      else $error("zero flag wrong");
   a_ones_mask: assert property (s_out_step |=>
      flg_reg[F_OMSK] == ((~result_reg & ~$past(msk_reg)) == '0))
      else $error("ones flag wrong");
   a_pat_match: assert property (s_out_step |=> flg_reg[F_PAT] ==
      (((result_reg ^ $past(pat_reg)) & ~$past(msk_reg)) == '0))
      else $error("pattern flag wrong");
   a_inv_pat: assert property (s_out_step |=> flg_reg[F_PATB] ==
      (((result_reg ^ ~$past(pat_reg)) & ~$past(msk_reg)) == '0))
      else $error("inverse pattern flag wrong");
   a_acc_over: assert property ((s_out_step and acc_sum > ACC_MAX)
      |=> flag_acc_over && !flag_acc_under) else $error("no overflow");
   a_acc_under: assert property ((s_out_step and acc_sum < ACC_MIN)
      |=> flag_acc_under && !flag_acc_over) else $error("no underflow");
   a_any_wrap: assert property (flag_acc_any_wrap ==
      (flag_acc_over || flag_acc_under)) else $error("wrap flag wrong");
   a_tick_sel: assert property (use_out && !clr_out &&
      !ck_tick[route_reg[16 +: 2]] |=> $stable(result_reg))
      else $error("output moved without its clock");
   a_grp_clear: assert property (clr_out |=> result_reg == '0
      && flg_reg == '0) else $error("group reset missed");
   a_irq_level: assert property (|(sts_reg & ien_reg) |=> irq)
      else $error("interrupt missing");
   a_bresp_hold: assert property (s_b_wait |=> bvalid_reg
      && $stable(bresp_reg)) else $error("write response dropped");
endmodule : dspmaf_top

// ==== test/dspmaf_fabric_model.sv ====
`timescale 1ns/1ps
module dspmaf_fabric_model (
   input wire logic aclk, // fabric clock
   input wire logic aresetn, // sync reset, low
   input wire logic [3:0] fire, // request one edge per routed clock
   output logic routed_clock_a, // routed clock pin 0
   output logic routed_clock_b, // routed clock pin 1
   output logic routed_clock_c, // routed clock pin 2
   output logic routed_clock_d // routed clock pin 3
);
   logic [2:0] cnt_reg [4];
   // each edge held long enough to pass the pin filter, then low again
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (!aresetn) begin
            cnt_reg[i] <= 3'h0;
         end else if (fire[i]) begin
            cnt_reg[i] <= 3'h5;
         end else if (cnt_reg[i] != 3'h0) begin
            cnt_reg[i] <= cnt_reg[i] - 3'h1;
         end
      end
   end
   assign routed_clock_a = cnt_reg[0] > 3'h1;
   assign routed_clock_b = cnt_reg[1] > 3'h1;
   assign routed_clock_c = cnt_reg[2] > 3'h1;
   assign routed_clock_d = cnt_reg[3] > 3'h1;
endmodule : dspmaf_fabric_model

// ==== test/dspmaf_top_tb.sv ====
`timescale 1ns/1ps
`include "dspmaf_map.svh"
module dspmaf_top_tb;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, fab_ce, fab_rst, fire;
   logic [1:0] bresp, rresp;
   logic routed_clock_a, routed_clock_b, routed_clock_c, routed_clock_d;
   logic [23:0] first_pair_x, first_pair_y, second_pair_x, second_pair_y;
   logic [31:0] result_q;
   logic flag_all_zero, flag_zero_masked, flag_ones_masked;
   logic flag_pattern_match, flag_inverse_pattern_match;
   logic flag_acc_over, flag_acc_under, flag_acc_any_wrap;
   int fails, num_checks;
   dspmaf_top DUT (.*);
   dspmaf_fabric_model FAB (.*);
   always #2.5 aclk = ~aclk;
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic lapse(input int n);
      if (n >= 400) begin
         fails++;
         $display("[FAIL] wait expired");
         summarize();
      end
   endtask : lapse
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      logic ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 400 && !(ad && wd); n++) begin
         @(posedge aclk);
         if (!ad && awready) begin
            awvalid <= 1'b0;
            ad = 1;
         end
         if (!wd && wready) begin
            wvalid <= 1'b0;
            wd = 1;
         end
      end
      lapse(n);
      for (n = 0; n < 400 && bvalid !== 1'b1; n++) @(posedge aclk);
      lapse(n);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      logic ad;
      ad = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 400 && !ad; n++) begin
         @(posedge aclk);
         if (arready === 1'b1) begin
            arvalid <= 1'b0;
            ad = 1;
         end
      end
      lapse(n);
      for (n = 0; n < 400; n++) begin
         @(posedge aclk);
         if (rvalid === 1'b1) begin
            break;
         end
      end
      lapse(n);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic ops(input logic [11:0] x0, y0, u0, v0, x1, y1, u1, v1);
      @(posedge aclk);
      first_pair_x <= {x1, x0};
      first_pair_y <= {y1, y0};
      second_pair_x <= {u1, u0};
      second_pair_y <= {v1, v0};
   endtask : ops
   task automatic pulse(input logic [3:0] m);
      @(posedge aclk);
      fire <= m;
      @(posedge aclk);
      fire <= 4'h0;
   endtask : pulse
   function automatic logic [31:0] mul(input logic [11:0] a, b);
      return {{20{a[11]}}, a} * {{20{b[11]}}, b};
   endfunction : mul
   function automatic logic [31:0] flags_of(input logic [31:0] r, p, m);
      return {27'h0, ((r ^ ~p) & ~m) == 0, ((r ^ p) & ~m) == 0,
              (r | m) == 32'hffff_ffff, (r & ~m) == 0, r == 0};
   endfunction : flags_of
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] s;
      logic [7:0] ad [5];
      ad = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], d, s);
         chk("reset value", 32'h0, d);
      end
      rd(8'h20, d, s);
      chk("unmapped rresp", 32'h2, 32'(s));
      wr(8'h24, 32'h1, s);
      chk("unmapped bresp", 32'h2, 32'(s));
      wr(`DSPMAF_RES, 32'h1234_5678, s);
      chk("ro bresp", 32'h0, 32'(s));
      wr(`DSPMAF_PAT, 32'h5a5a_a5a5, s);
      rd(`DSPMAF_PAT, d, s);
      chk("pattern", 32'h5a5a_a5a5, d);
   endtask : t_regs
   task automatic t_flags;
      logic [31:0] r;
      logic [1:0] s;
      logic [11:0] xv [4];
      logic [11:0] yv [4];
      xv = '{12'h003, 12'h000, 12'h001, 12'hff9};
      yv = '{12'h002, 12'h005, 12'hfff, 12'h001};
      wr(`DSPMAF_CTRL, 32'h0, s);
      wr(`DSPMAF_PAT, 32'h0000_0006, s);
      wr(`DSPMAF_MSK, 32'hffff_ff00, s);
      for (int i = 0; i < 4; i++) begin
         ops(xv[i], yv[i], 12'h009, 12'h009, 12'h064, 12'h064, 12'h3, 12'h3);
         wt(2);
         r = mul(xv[i], yv[i]);
         chk("plain product", r, result_q);
         chk("flags", flags_of(r, 32'h6, 32'hffff_ff00),
             {27'h0, flag_inverse_pattern_match, flag_pattern_match,
              flag_ones_masked, flag_zero_masked, flag_all_zero});
      end
   endtask : t_flags
   task automatic t_dual;
      logic [31:0] p0, p1;
      logic [1:0] s;
      for (int c = 0; c < 4; c++) begin
         wr(`DSPMAF_CTRL, {29'h0, c[1:0], 1'b1}, s);
         ops(12'h003, 12'h005, 12'h007, 12'h002,
             12'hffc, 12'h006, 12'h00a, 12'h00a);
         wt(2);
         p0 = c[0] ? mul(12'h7, 12'h2) - mul(12'h3, 12'h5)
                   : mul(12'h7, 12'h2) + mul(12'h3, 12'h5);
         p1 = c[1] ? mul(12'ha, 12'ha) - mul(12'hffc, 12'h6)
                   : mul(12'ha, 12'ha) + mul(12'hffc, 12'h6);
         chk("dual sum", p0 + p1, result_q);
      end
   endtask : t_dual
   task automatic t_acc(input logic neg);
      int n;
      logic [31:0] d, b;
      logic [1:0] s;
      logic [11:0] v;
      v = neg ? 12'h7ff : 12'h800;
      b = neg ? 32'h40 : 32'h20;
      wr(`DSPMAF_CTRL, 32'h9, s);
      wr(`DSPMAF_IEN, b, s);
      ops(12'h800, v, 12'h800, v, 12'h800, v, 12'h800, v);
      for (n = 0; n < 400 && (neg ? flag_acc_under : flag_acc_over) !== 1'b1;
           n++) wt(1);
      lapse(n);
      chk("any wrap", 32'h1, 32'(flag_acc_any_wrap));
      chk("other wrap", 32'h0,
          32'(neg ? flag_acc_over : flag_acc_under));
      chk("wrapped sign", 32'(!neg), 32'(result_q[31]));
      wt(2);
      chk("irq raised", 32'h1, 32'(irq));
      wr(`DSPMAF_IEN, 32'h0, s);
      wt(2);
      chk("irq masked", 32'h0, 32'(irq));
      wr(`DSPMAF_CTRL, 32'h1, s);
      rd(`DSPMAF_STS, d, s);
      chk("status set", b, d & b);
      wr(`DSPMAF_STS, 32'hff, s);
      wr(`DSPMAF_IEN, b, s);
      rd(`DSPMAF_STS, d, s);
      chk("status cleared", 32'h0, d & b);
      wt(2);
      chk("irq cleared", 32'h0, 32'(irq));
   endtask : t_acc
   task automatic t_outreg;
      logic [1:0] s;
      wr(`DSPMAF_ROUTE, 32'h0001_0000, s);
      wr(`DSPMAF_CTRL, 32'h40, s);
      fab_rst <= 4'h1;
      ops(12'h002, 12'h003, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0);
      wt(12);
      chk("group reset", 32'h0, result_q);
      fab_rst <= 4'h0;
      wt(12);
      chk("no routed edge", 32'h0, result_q);
      pulse(4'h2);
      wt(12);
      chk("routed edge", 32'h6, result_q);
      fab_ce <= 4'he;
      ops(12'h004, 12'h004, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0);
      pulse(4'h2);
      wt(12);
      chk("enable low", 32'h6, result_q);
      fab_ce <= 4'hf;
      pulse(4'h1);
      wt(12);
      chk("other clock", 32'h6, result_q);
      pulse(4'h2);
      wt(12);
      chk("chosen clock", 32'h10, result_q);
      wr(`DSPMAF_ROUTE, 32'h0001_0101, s);
      wr(`DSPMAF_CTRL, 32'h70, s);
      ops(12'h005, 12'h005, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0);
      repeat (3) begin
         pulse(4'h2);
         wt(12);
      end
      chk("staged product", 32'h19, result_q);
      ops(12'h006, 12'h006, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0);
      repeat (2) begin
         pulse(4'h2);
         wt(12);
      end
      chk("stage delay", 32'h19, result_q);
      pulse(4'h2);
      wt(12);
      chk("staged new", 32'h24, result_q);
   endtask : t_outreg
   initial begin
      {aclk, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, fab_rst, fire} = 56'h0;
      {first_pair_x, first_pair_y, second_pair_x, second_pair_y} = 96'h0;
      aresetn = 1'b0;
      wstrb = 4'hf;
      fab_ce = 4'hf;
      fails = 0;
      num_checks = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_flags();
      t_dual();
      t_acc(1'b0);
      t_acc(1'b1);
      t_outreg();
      summarize();
   end
endmodule : dspmaf_top_tb
